//--- hw/aao_pkg.sv
// Package: operation codes, flag layout, request and result carriers for the add/AND datapath
package aao_pkg;

   localparam int unsigned DATA_W = 8;

   // Operation selects, as issued by the instruction decoder
   typedef enum logic [2:0] {
      AAO_OP_ADD_CARRY_TO_MEMORY,
      AAO_OP_ADD_MEM_TO_ACC,
      AAO_OP_ADD_IMM_TO_ACC,
      AAO_OP_ADD_ACCUMULATOR_TO_MEMORY,
      AAO_OP_AND_MEM_TO_ACC,
      AAO_OP_AND_IMM_TO_ACC
   } aao_op_e;

   // Flag positions inside the packed flag word
   localparam int unsigned FLAG_CARRY_POS      = 0;
   localparam int unsigned FLAG_HALF_CARRY_POS = 1;
   localparam int unsigned FLAG_ZERO_POS       = 2;
   localparam int unsigned FLAG_OVERFLOW_POS   = 3;

   // Reset values
   localparam logic [7:0] ACCUMULATOR_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET       = 4'h0;

   typedef struct packed {
      logic overflow_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } aao_flags_s;

   // One instruction request from the decoder
   typedef struct packed {
      logic       valid;
      aao_op_e    op;
      logic [7:0] mem_data;
      logic [7:0] imm_data;
   } aao_req_s;

   // Memory write-back towards the data memory port
   typedef struct packed {
      logic       write;
      logic [7:0] data;
   } aao_mem_wr_s;

endpackage : aao_pkg

//--- hw/aao_adder.sv
// Eight-bit adder with carry, half-carry and signed overflow outputs
`timescale 1ns/1ps
`default_nettype none

module aao_adder (
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   output logic      [7:0] sum,
   output logic            carry_out,
   output logic            half_carry_out,
   output logic            overflow_out
);

   logic [4:0] low_nibble;
   logic [8:0] full_sum;

   // Nibble sum taken separately so bit-3 carry is exact
   always_comb begin
      low_nibble     = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full_sum       = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      sum            = full_sum[7:0];
      carry_out      = full_sum[8];
      half_carry_out = low_nibble[4];
      // Same-sign operands giving an opposite-sign result
      overflow_out   = (a[7] == b[7]) && (full_sum[7] != a[7]);
   end

endmodule // aao_adder
`default_nettype wire

//--- hw/aao_datapath.sv
// Add and AND datapath: accumulator, flags and memory write-back
`timescale 1ns/1ps
`default_nettype none

module aao_datapath (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 clk_en,
   input  wire aao_pkg::aao_req_s    req,
   output logic                [7:0] accumulator,
   output aao_pkg::aao_flags_s       flags,
   output aao_pkg::aao_mem_wr_s      mem_wr
);

   // Whole module state in one packed struct
   typedef struct packed {
      logic [7:0]           accumulator;
      aao_pkg::aao_flags_s  flags;
      aao_pkg::aao_mem_wr_s mem_wr;
   } aao_state_s;

   aao_state_s state;
   aao_state_s next_state;

   logic [7:0] add_b;
   logic       add_cin;
   logic [7:0] add_sum;
   logic       add_carry;
   logic       add_half;
   logic       add_ovf;

   // True for the four add operations
   function automatic logic is_add(input aao_pkg::aao_op_e op);
      return op inside {aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY, aao_pkg::AAO_OP_ADD_MEM_TO_ACC,
                        aao_pkg::AAO_OP_ADD_IMM_TO_ACC, aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY};
   endfunction

   // True where the result is written to data memory
   function automatic logic to_memory(input aao_pkg::aao_op_e op);
      return op inside {aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY, aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY};
   endfunction

   // Operand select: only the immediate forms use the instruction byte
   always_comb begin
      add_b   = (req.op == aao_pkg::AAO_OP_ADD_IMM_TO_ACC) ? req.imm_data : req.mem_data;
      // Carry-in only for add-with-carry; plain adds ignore the flag
      add_cin = (req.op == aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY) ? state.flags.carry_flag : 1'b0;
   end

   aao_adder u_adder (
      .a              (state.accumulator),
      .b              (add_b),
      .cin            (add_cin),
      .sum            (add_sum),
      .carry_out      (add_carry),
      .half_carry_out (add_half),
      .overflow_out   (add_ovf)
   );

   // Next-state: results and flags by operation
   always_comb begin
      next_state              = state;
      next_state.mem_wr.write = 1'b0;  // Write strobe lasts one enabled cycle
      if (req.valid) begin
         case (req.op)
            aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY,
            aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY: begin
               next_state.mem_wr.write = 1'b1;
               next_state.mem_wr.data  = add_sum;
            end
            aao_pkg::AAO_OP_ADD_MEM_TO_ACC,
            aao_pkg::AAO_OP_ADD_IMM_TO_ACC: begin
               next_state.accumulator = add_sum;
            end
            aao_pkg::AAO_OP_AND_MEM_TO_ACC: begin
               next_state.accumulator     = state.accumulator & req.mem_data;
               next_state.flags.zero_flag = ((state.accumulator & req.mem_data) == 8'h00);
            end
            aao_pkg::AAO_OP_AND_IMM_TO_ACC: begin
               next_state.accumulator     = state.accumulator & req.imm_data;
               next_state.flags.zero_flag = ((state.accumulator & req.imm_data) == 8'h00);
            end
            default: begin
               next_state = state;
               next_state.mem_wr.write = 1'b0;
            end
         endcase
         // All four adds share the full flag update
         if (is_add(req.op)) begin
            next_state.flags.overflow_flag   = add_ovf;
            next_state.flags.zero_flag       = (add_sum == 8'h00);
            next_state.flags.half_carry_flag = add_half;
            next_state.flags.carry_flag      = add_carry;
         end
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state.accumulator <= aao_pkg::ACCUMULATOR_RESET;
         state.flags       <= aao_pkg::FLAGS_RESET;
         state.mem_wr      <= '0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Outputs come straight from the state flops
   assign accumulator = state.accumulator;
   assign flags       = state.flags;
   assign mem_wr      = state.mem_wr;

   // Assertions
   logic issued;
   assign issued = req.valid && clk_en;

   sequence s_adc_req;
      issued && req.op == aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY;
   endsequence

   sequence s_adc_wb(logic [7:0] a, logic [7:0] m, logic c);
      mem_wr.write && mem_wr.data == 8'(a + m + {7'h00, c});
   endsequence

   property p_adc_mem;
      @(posedge ref_clk) disable iff (!rst_n)
      s_adc_req |=> s_adc_wb($past(accumulator), $past(req.mem_data), $past(flags.carry_flag));
   endproperty
   a_adc_mem: assert property (p_adc_mem) else $error("add with carry wrote wrong memory value");

   property p_add_mem_acc;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && req.op == aao_pkg::AAO_OP_ADD_MEM_TO_ACC
      |=> accumulator == 8'($past(accumulator) + $past(req.mem_data)) && !mem_wr.write;
   endproperty
   a_add_mem_acc: assert property (p_add_mem_acc) else $error("add memory to accumulator wrong");

   property p_add_imm;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && req.op == aao_pkg::AAO_OP_ADD_IMM_TO_ACC
      |=> accumulator == 8'($past(accumulator) + $past(req.imm_data));
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

   property p_add_acc_mem;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && req.op == aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY
      |=> mem_wr.write && mem_wr.data == 8'($past(accumulator) + $past(req.mem_data)) && $stable(accumulator);
   endproperty
   a_add_acc_mem: assert property (p_add_acc_mem) else $error("add accumulator to memory wrong");

   property p_add_flags;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && is_add(req.op)
      |=> flags.zero_flag == ((to_memory($past(req.op)) ? mem_wr.data : accumulator) == 8'h00);
   endproperty
   a_add_flags: assert property (p_add_flags) else $error("add zero flag mismatch");

   property p_and_mem;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && req.op == aao_pkg::AAO_OP_AND_MEM_TO_ACC
      |=> accumulator == ($past(accumulator) & $past(req.mem_data));
   endproperty
   a_and_mem: assert property (p_and_mem) else $error("AND memory result wrong");

   property p_and_imm;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && req.op == aao_pkg::AAO_OP_AND_IMM_TO_ACC
      |=> accumulator == ($past(accumulator) & $past(req.imm_data));
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("AND immediate result wrong");

   property p_and_flags;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && !is_add(req.op)
      |=> $stable(flags.carry_flag) && $stable(flags.half_carry_flag) && $stable(flags.overflow_flag)
          && flags.zero_flag == (accumulator == 8'h00);
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("AND changed a flag other than zero");

   property p_carry_out;
      @(posedge ref_clk) disable iff (!rst_n)
      issued && req.op == aao_pkg::AAO_OP_ADD_MEM_TO_ACC
      |=> flags.carry_flag == (({1'b0, $past(accumulator)} + {1'b0, $past(req.mem_data)}) > 9'h0ff)
          && flags.half_carry_flag == (({1'b0, $past(accumulator[3:0])} + {1'b0, $past(req.mem_data[3:0])}) > 5'h0f);
   endproperty
   a_carry_out: assert property (p_carry_out) else $error("carry or half-carry wrong");

   // Carry-in takes part in the carry, half-carry and overflow flags of add-with-carry
   property p_adc_flags;
      @(posedge ref_clk) disable iff (!rst_n)
      s_adc_req
      |=> flags.carry_flag == (({1'b0, $past(accumulator)} + {1'b0, $past(req.mem_data)}
                                + {8'h00, $past(flags.carry_flag)}) > 9'h0ff)
          && flags.half_carry_flag == (({1'b0, $past(accumulator[3:0])} + {1'b0, $past(req.mem_data[3:0])}
                                        + {4'h0, $past(flags.carry_flag)}) > 5'h0f)
          && flags.overflow_flag == (($past(accumulator[7]) == $past(req.mem_data[7]))
                                     && (mem_wr.data[7] != $past(accumulator[7])));
   endproperty
   a_adc_flags: assert property (p_adc_flags) else $error("add with carry flags wrong");

   // Clock enable low must hold all state, a pending write pulse included
   property p_freeze;
      @(posedge ref_clk) disable iff (!rst_n)
      !clk_en |=> $stable(state);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

   // Only a memory-destination add may leave the write strobe raised
   property p_wr_pulse;
      @(posedge ref_clk) disable iff (!rst_n)
      clk_en && !(req.valid && to_memory(req.op)) |=> !mem_wr.write;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe outlived its operation");

endmodule // aao_datapath
`default_nettype wire

//--- test/aao_mem_model.sv
// Partner model: data memory port that answers reads and takes write-backs
`timescale 1ns/1ps
`default_nettype none

module aao_mem_model (
   input  wire logic                 ref_clk,
   input  wire logic                 take,
   input  wire logic           [1:0] addr,
   input  wire aao_pkg::aao_mem_wr_s mem_wr,
   output logic                [7:0] mem_byte
);
   // Boundary bytes: signed max, signed min, all ones, low nibble full
   logic [7:0] mem [4] = '{8'h7f, 8'h80, 8'hff, 8'h0f};
   logic [1:0] wr_addr;

   // Addressed byte is offered at once, as the decoder fetches it
   assign mem_byte = mem[addr];

   // Write-back lands one edge late, so the place of the taken op is kept
   always @(posedge ref_clk) begin
      if (take) wr_addr <= addr;
      if (mem_wr.write) mem[wr_addr] <= mem_wr.data;
   end
endmodule // aao_mem_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the add and AND datapath
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic                 ref_clk, rst_n, clk_en, valid;
   logic           [1:0] addr;
   logic           [7:0] imm, mem_byte, acc, e_acc, e_wd;
   logic           [7:0] e_mem [4];
   logic                 e_wr;
   aao_pkg::aao_op_e     op;
   aao_pkg::aao_req_s    req;
   aao_pkg::aao_flags_s  flags, e_fl;
   aao_pkg::aao_mem_wr_s mem_wr;
   int                   err_count = 0;
   int                   total_checks = 0;

   // Request assembled from bench fields and the memory byte
   assign req = '{valid, op, mem_byte, imm};

   aao_datapath aao_datapath_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
      .accumulator(acc), .flags(flags), .mem_wr(mem_wr));
   aao_mem_model aao_mem_model_i (.ref_clk(ref_clk), .take(valid && clk_en), .addr(addr),
      .mem_wr(mem_wr), .mem_byte(mem_byte));

   // 50 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Reference sum: flags packed {ov, z, ac, c} above the byte
   function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      s = a + b + ci;
      return {a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, (a[3:0] + b[3:0] + ci) > 5'h0f, s[8], s[7:0]};
   endfunction

   // One taken op; expectation worked out before the edge, judged after it
   task automatic step(input aao_pkg::aao_op_e o, input logic [1:0] a, input logic [7:0] x);
      logic [11:0] r;
      logic [7:0]  s;
      valid = 1'b1;
      op = o;
      addr = a;
      imm = x;
      s = (o == aao_pkg::AAO_OP_ADD_IMM_TO_ACC || o == aao_pkg::AAO_OP_AND_IMM_TO_ACC) ? x : e_mem[a];
      r = add8(e_acc, s, o == aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY && e_fl.carry_flag);
      e_wr = 1'b0;
      if (o == aao_pkg::AAO_OP_AND_MEM_TO_ACC || o == aao_pkg::AAO_OP_AND_IMM_TO_ACC) begin
         e_acc = e_acc & s;
         e_fl.zero_flag = (e_acc == 8'h00);
      end else begin
         e_fl = r[11:8];
         if (o == aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY || o == aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY) begin
            e_wr = 1'b1;
            e_wd = r[7:0];
            e_mem[a] = r[7:0];
         end else begin
            e_acc = r[7:0];
         end
      end
      @(negedge ref_clk);
      cmp({acc, flags, mem_wr}, {e_acc, e_fl, e_wr, e_wd});
   endtask

   // No request for a cycle: write pulse must have ended
   task automatic idle;
      valid = 1'b0;
      e_wr = 1'b0;
      @(negedge ref_clk);
      cmp({acc, flags, mem_wr}, {e_acc, e_fl, e_wr, e_wd});
   endtask

   // Accumulator adds through signed overflow and carry-out to zero
   task automatic t_add_acc;
      step(aao_pkg::AAO_OP_ADD_MEM_TO_ACC, 2'd0, 8'h00);
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd1, 8'h01);
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd1, 8'h80);
      idle();
   endtask

   // Memory adds, the add-with-carry one run with carry set, then read the result back
   task automatic t_add_mem;
      step(aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY, 2'd2, 8'h00);
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd0, 8'hff);
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd0, 8'h01);
      step(aao_pkg::AAO_OP_ADD_CARRY_TO_MEMORY, 2'd3, 8'h00);
      idle();
      step(aao_pkg::AAO_OP_ADD_MEM_TO_ACC, 2'd3, 8'h00);
   endtask

   // AND forms with overflow, half-carry and carry all set beforehand, which must survive
   task automatic t_and;
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd0, 8'h78);
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd0, 8'h88);
      step(aao_pkg::AAO_OP_AND_IMM_TO_ACC, 2'd0, 8'h1c);
      step(aao_pkg::AAO_OP_AND_MEM_TO_ACC, 2'd1, 8'h00);
      idle();
   endtask

   // Request held while disabled is not taken; a write pulse stands through the freeze
   task automatic t_freeze;
      step(aao_pkg::AAO_OP_ADD_ACCUMULATOR_TO_MEMORY, 2'd0, 8'h00);
      clk_en = 1'b0;
      valid = 1'b1;
      op = aao_pkg::AAO_OP_ADD_IMM_TO_ACC;
      imm = 8'h01;
      repeat (3) @(negedge ref_clk);
      cmp({acc, flags, mem_wr}, {e_acc, e_fl, e_wr, e_wd});
      clk_en = 1'b1;
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd0, 8'h01);
      idle();
   endtask

   // Reset in mid-run clears all outputs; request taken at the first edge after release
   task automatic t_reset;
      rst_n = 1'b0;
      {e_acc, e_fl, e_wr, e_wd} = '0;
      @(negedge ref_clk);
      cmp({acc, flags, mem_wr}, {e_acc, e_fl, e_wr, e_wd});
      rst_n = 1'b1;
      step(aao_pkg::AAO_OP_ADD_IMM_TO_ACC, 2'd0, 8'h33);
      idle();
   endtask

   task automatic wrap_up;
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence: reset 16 cycles, reset values, then scenarios
   initial begin
      {rst_n, valid, addr, imm} = '0;
      clk_en = 1'b1;
      op = aao_pkg::AAO_OP_ADD_IMM_TO_ACC;
      {e_acc, e_fl, e_wr, e_wd} = '0;
      e_mem = '{8'h7f, 8'h80, 8'hff, 8'h0f};
      repeat (16) @(negedge ref_clk);
      cmp({acc, flags, mem_wr}, 21'h0);
      rst_n = 1'b1;
      t_add_acc();
      t_add_mem();
      t_and();
      t_freeze();
      t_reset();
      wrap_up();
   end

   // Watchdog: scenarios need well under 100 cycles
   initial begin
      #20000;
      err_count++;
      wrap_up();
   end
endmodule // tb
`default_nettype wire
